/* File: core/flash_guard.sv */
// flash write-protection logic with serial command front end and apb
`timescale 1ns/1ps
module flash_guard
  import flash_guard_pkg::*;
#(
  parameter int PADDR_W = 8
) (
  input  wire logic               clk_sys,
  input  wire logic               resetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [PADDR_W-1:0] paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               spi_sck,
  input  wire logic               spi_cs_n,
  input  wire logic               spi_si,
  input  wire logic               wp_n,
  output logic                    prog_start,
  output logic                    erase_start,
  output logic                    op_chip,
  output logic      [23:0]        op_addr,
  output logic                    sr_write_start,
  output logic      [7:0]         sr_value,
  output logic                    irq
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic sck_s1, sck_s2, sck_d;
  logic cs_s1, cs_s2, cs_d;
  logic si_s1, si_s2;
  logic wp_s1, wp_s2;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_d  <= 1'b0;
      cs_s1  <= 1'b1;
      cs_s2  <= 1'b1;
      cs_d   <= 1'b1;
      si_s1  <= 1'b0;
      si_s2  <= 1'b0;
      wp_s1  <= 1'b0;
      wp_s2  <= 1'b0;
    end else begin
      sck_s1 <= spi_sck;
      sck_s2 <= sck_s1;
      sck_d  <= sck_s2;
      cs_s1  <= spi_cs_n;
      cs_s2  <= cs_s1;
      cs_d   <= cs_s2;
      si_s1  <= spi_si;
      si_s2  <= si_s1;
      wp_s1  <= wp_n;
      wp_s2  <= wp_s1;
    end
  end

  logic sck_rise, frame_end;
  assign sck_rise  = sck_s2 & ~sck_d & ~cs_s2;
  assign frame_end = cs_s2 & ~cs_d;

  // ----------------------------------------------------------------
  // guarded range decode
  // ----------------------------------------------------------------
  function automatic logic in_region(input logic [22:0] a,
                                     input logic [4:0]  g);
    logic [2:0]  code;
    logic [23:0] size;
    logic        hit;
    code = g[2:0];
    size = '0;
    hit  = 1'b0;
    if (code == CODE_NONE) begin
      hit = 1'b0;
    end else if (code == CODE_ALL) begin
      hit = 1'b1;
    end else begin
      if (!g[4]) begin
        size = SIZE_UNIT_BIG << (code - 3'h1);
      // small end areas cap at 32KB
      end else if (code >= CODE_SMALL_CAP) begin
        size = SIZE_SMALL_MAX;
      end else begin
        size = SIZE_UNIT_SMALL << (code - 3'h1);
      end
      if (!g[3]) begin
        hit = {1'b0, a} >= (ARRAY_TOP - size);
      end else begin
        hit = {1'b0, a} < size;
      end
    end
    return hit;
  endfunction : in_region

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [5:0]       bits, next_bits;
  logic [31:0]      shift, next_shift;
  logic [31:0]      head, next_head;
  logic [7:0]       sr, next_sr;
  logic             write_enable_latch, next_wel;
  logic             violation, next_violation;
  logic [IRQ_W-1:0] irq_st, next_irq_st;
  logic [IRQ_W-1:0] irq_mask, next_irq_mask;
  logic [31:0]      rdata, next_rdata;
  logic             prog_q, next_prog_q;
  logic             erase_q, next_erase_q;
  logic             chip_q, next_chip_q;
  logic [23:0]      addr_q, next_addr_q;
  logic             srw_q, next_srw_q;
  logic [7:0]       op;
  logic [23:0]      tgt;
  logic [4:0]       guard;
  logic             invert, guarded, any_guard, sr_ok;
  logic             apb_wr, apb_rd, mapped;
  logic [IRQ_W-1:0] ev;

  assign guard  = sr[SB_GUARD_LSB +: SB_GUARD_W];
  assign invert = sr[SB_INVERT];

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_bits      = bits;
    next_shift     = shift;
    next_head      = head;
    next_sr        = sr;
    next_wel       = write_enable_latch;
    next_violation = violation;
    next_irq_mask  = irq_mask;
    next_rdata     = rdata;
    next_prog_q    = 1'b0;
    next_erase_q   = 1'b0;
    next_chip_q    = chip_q;
    next_addr_q    = addr_q;
    next_srw_q     = 1'b0;
    ev             = '0;
    op             = shift[7:0];
    tgt            = head[23:0];
    // status write gate by lock mode
    case ({sr[SB_LOCK_HI], sr[SB_LOCK_LO]})
      2'b00: sr_ok = write_enable_latch;
      2'b01: sr_ok = wp_s2 & write_enable_latch;
      default: sr_ok = 1'b0;
    endcase
    guarded   = in_region(tgt[22:0], guard) ^ invert;
    any_guard = (guard != '0) | invert;
    // serial shifter
    if (cs_s2) begin
      next_bits = '0;
    end else if (sck_rise) begin
      next_shift = {shift[30:0], si_s2};
      if (bits == BITS_HEAD_END) begin
        next_head = {shift[30:0], si_s2};
      end
      if (bits != BITS_SATURATE) begin
        next_bits = bits + 6'h01;
      end
    end
    // command execute at frame end
    if (frame_end) begin
      if (bits == BITS_CMD_ONLY) begin
        if (op == OP_WRITE_ENABLE) begin
          next_wel = 1'b1;
        end else if (op == OP_WRITE_DISABLE) begin
          next_wel = 1'b0;
        end else if ((op == OP_CHIP_ERASE_A || op == OP_CHIP_ERASE_B)
                     && write_enable_latch) begin
          if (any_guard) begin
            next_violation        = 1'b1;
            ev[IRQ_VIOLATION]     = 1'b1;
          end else begin
            next_erase_q          = 1'b1;
            next_chip_q           = 1'b1;
            next_addr_q           = '0;
            ev[IRQ_OP_DONE]       = 1'b1;
          end
          next_wel = 1'b0;
        end
      end else if (bits == BITS_CMD_DATA && shift[15:8] == OP_STATUS_WRITE) begin
        if (sr_ok) begin
          next_sr         = shift[7:0];
          next_srw_q      = 1'b1;
          next_wel        = 1'b0;
          ev[IRQ_OP_DONE] = 1'b1;
        end else begin
          ev[IRQ_REFUSED] = 1'b1;
        end
      end else if (bits >= BITS_CMD_ADDR && bits[2:0] == 3'h0 && write_enable_latch) begin
        op = head[31:24];
        if (op == OP_PAGE_PROGRAM || op == OP_SECTOR_ERASE) begin
          next_wel = 1'b0;
          if (guarded) begin
            next_violation    = 1'b1;
            ev[IRQ_VIOLATION] = 1'b1;
          end else begin
            next_prog_q     = (op == OP_PAGE_PROGRAM);
            next_erase_q    = (op == OP_SECTOR_ERASE);
            next_chip_q     = 1'b0;
            next_addr_q     = tgt;
            ev[IRQ_OP_DONE] = 1'b1;
          end
        end
      end
    end
    // apb side
    apb_wr = psel & penable & pwrite;
    apb_rd = psel & ~penable & ~pwrite;
    mapped = 1'b1;
    if (paddr[7:0] == REG_GUARD_STATE) begin
      next_rdata = {21'h0, wp_s2, violation, write_enable_latch, sr};
    end else if (paddr[7:0] == REG_CONTROL) begin
      next_rdata = '0;
      if (apb_wr && pwdata[CTRL_SOFT_RESET]) begin
        next_violation = 1'b0;
        next_wel       = 1'b0;
      end
    end else if (paddr[7:0] == REG_IRQ_STATUS) begin
      next_rdata = {29'h0, irq_st};
    end else if (paddr[7:0] == REG_IRQ_MASK) begin
      next_rdata = {29'h0, irq_mask};
      if (apb_wr) begin
        next_irq_mask = pwdata[IRQ_W-1:0];
      end
    end else if (paddr[7:0] == REG_LAST_ADDR) begin
      next_rdata = {8'h0, addr_q};
    end else begin
      next_rdata = '0;
      mapped     = 1'b0;
    end
    if (!apb_rd) begin
      next_rdata = rdata;
    end
    if (PADDR_W > 8 && paddr[PADDR_W-1:0] != {{(PADDR_W-8){1'b0}},
                                               paddr[7:0]}) begin
      mapped = 1'b0;
    end
    // sticky events, set wins over clear
    if (apb_wr && mapped && paddr[7:0] == REG_IRQ_STATUS) begin
      next_irq_st = (irq_st & ~pwdata[IRQ_W-1:0]) | ev;
    end else begin
      next_irq_st = irq_st | ev;
    end
    if (ev[IRQ_VIOLATION]) begin
      next_violation = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      bits      <= '0;
      shift     <= '0;
      head      <= '0;
      sr        <= SB_RESET;
      write_enable_latch       <= 1'b0;
      violation <= 1'b0;
      irq_st    <= IRQ_RESET;
      irq_mask  <= IRQ_RESET;
      rdata     <= '0;
      prog_q    <= 1'b0;
      erase_q   <= 1'b0;
      chip_q    <= 1'b0;
      addr_q    <= '0;
      srw_q     <= 1'b0;
    end else begin
      bits      <= next_bits;
      shift     <= next_shift;
      head      <= next_head;
      sr        <= next_sr;
      write_enable_latch       <= next_wel;
      violation <= next_violation;
      irq_st    <= next_irq_st;
      irq_mask  <= next_irq_mask;
      rdata     <= next_rdata;
      prog_q    <= next_prog_q;
      erase_q   <= next_erase_q;
      chip_q    <= next_chip_q;
      addr_q    <= next_addr_q;
      srw_q     <= next_srw_q;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata         = rdata;
  assign pready         = 1'b1;
  assign pslverr        = psel & penable & ~mapped;
  assign prog_start     = prog_q;
  assign erase_start    = erase_q;
  assign op_chip        = chip_q;
  assign op_addr        = addr_q;
  assign sr_write_start = srw_q;
  assign sr_value       = sr;
  assign irq            = |(irq_st & irq_mask);

endmodule : flash_guard

/* File: core/flash_guard_pkg.sv */
// constants for the flash write-protection block
package flash_guard_pkg;

  // ----------------------------------------------------------------
  // serial command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
  localparam logic [7:0] OP_PAGE_PROGRAM  = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE  = 8'h20;
  localparam logic [7:0] OP_CHIP_ERASE_A  = 8'hC7;
  localparam logic [7:0] OP_CHIP_ERASE_B  = 8'h60;

  // ----------------------------------------------------------------
  // frame lengths in serial bits
  // ----------------------------------------------------------------
  localparam logic [5:0] BITS_CMD_ONLY = 6'h08;
  localparam logic [5:0] BITS_CMD_DATA = 6'h10;
  localparam logic [5:0] BITS_HEAD_END = 6'h1F;
  localparam logic [5:0] BITS_CMD_ADDR = 6'h20;
  localparam logic [5:0] BITS_SATURATE = 6'h28;

  // ----------------------------------------------------------------
  // protection status byte layout
  // ----------------------------------------------------------------
  localparam int         SB_GUARD_LSB = 0;
  localparam int         SB_GUARD_W   = 5;
  localparam int         SB_INVERT    = 5;
  localparam int         SB_LOCK_LO   = 6;
  localparam int         SB_LOCK_HI   = 7;
  localparam logic [7:0] SB_RESET     = 8'h00;

  // ----------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------
  localparam logic [23:0] ARRAY_TOP       = 24'h800000;
  localparam logic [23:0] SIZE_UNIT_BIG   = 24'h020000;
  localparam logic [23:0] SIZE_UNIT_SMALL = 24'h001000;
  localparam logic [23:0] SIZE_SMALL_MAX  = 24'h008000;
  localparam logic [2:0]  CODE_NONE       = 3'h0;
  localparam logic [2:0]  CODE_ALL        = 3'h7;
  localparam logic [2:0]  CODE_SMALL_CAP  = 3'h4;

  // ----------------------------------------------------------------
  // apb register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_GUARD_STATE = 8'h00;
  localparam logic [7:0] REG_CONTROL     = 8'h04;
  localparam logic [7:0] REG_IRQ_STATUS  = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK    = 8'h0C;
  localparam logic [7:0] REG_LAST_ADDR   = 8'h10;

  // guard state read fields
  localparam int GS_WEL       = 8;
  localparam int GS_VIOLATION = 9;
  localparam int GS_WP_LEVEL  = 10;

  // control write fields
  localparam int CTRL_SOFT_RESET = 0;

  // interrupt bits
  localparam int          IRQ_W         = 3;
  localparam int          IRQ_REFUSED   = 0;
  localparam int          IRQ_VIOLATION = 1;
  localparam int          IRQ_OP_DONE   = 2;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

endpackage : flash_guard_pkg

/* File: tb/flash_guard_chk.sv */
// assertion checker for the flash write-protection block
`timescale 1ns/1ps
module flash_guard_chk
  import flash_guard_pkg::*;
#(
  parameter int PADDR_W = 8
) (
  input wire logic               clk_sys,
  input wire logic               resetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0]        pwdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               spi_cs_n,
  input wire logic               wp_n,
  input wire logic               prog_start,
  input wire logic               erase_start,
  input wire logic [23:0]        op_addr,
  input wire logic               sr_write_start,
  input wire logic [7:0]         sr_value,
  input wire logic               irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic mapped;
  assign mapped = paddr inside {REG_GUARD_STATE, REG_CONTROL,
    REG_IRQ_STATUS, REG_IRQ_MASK, REG_LAST_ADDR};
  // ------------------------------------------------
  // checks
  // ------------------------------------------------
  bus_error_a : assert property (psel && penable |-> pslverr == !mapped)
    else $error("pslverr does not follow the address map");
  no_wait_a : assert property (psel && penable |-> pready)
    else $error("access phase held off");
  irq_mask_a : assert property (psel && penable && pwrite
    && paddr == REG_IRQ_MASK && pwdata[2:0] == 3'h0 |=> !irq)
    else $error("irq high with every source masked");
  one_start_a : assert property ($onehot0({prog_start, erase_start,
    sr_write_start}))
    else $error("two start pulses at once");
  start_pulse_a : assert property (prog_start || erase_start |=>
    !prog_start && !erase_start)
    else $error("start pulse longer than one cycle");
  after_frame_a : assert property (prog_start || erase_start
    |-> spi_cs_n && $past(spi_cs_n) && $past(spi_cs_n, 2))
    else $error("operation started inside a frame");
  lock_high_a : assert property (sr_write_start |->
    !$past(sr_value[7], 2))
    else $error("status write accepted while locked");
  pin_lock_a : assert property (sr_write_start
    && $past(sr_value[7:6], 2) == 2'b01 |-> $past(wp_n, 2))
    else $error("status write accepted with protect pin low");
  sr_hold_a : assert property ($changed(sr_value)
    |-> sr_write_start || $past(sr_write_start))
    else $error("status byte changed without an accepted write");
  addr_hold_a : assert property ($changed(op_addr) |-> prog_start
    || erase_start || $past(prog_start || erase_start))
    else $error("target address changed without a start");
endmodule : flash_guard_chk

bind flash_guard flash_guard_chk #(.PADDR_W(PADDR_W)) flash_guard_chk_i (
  .clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .spi_cs_n, .wp_n, .prog_start, .erase_start, .op_addr,
  .sr_write_start, .sr_value, .irq);

/* File: tb/spi_host_model.sv */
// serial host model that sends command frames to the guard block
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic clk_sys,
  output logic      spi_sck,
  output logic      spi_cs_n,
  output logic      spi_si
);
  initial begin
    spi_sck  = 1'b0;
    spi_cs_n = 1'b1;
    spi_si   = 1'b0;
  end
  // ------------------------------------------------
  // one frame, msb first, 80 ns bit period
  // ------------------------------------------------
  task automatic send(input logic [39:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      repeat (4) @(posedge clk_sys);
      spi_cs_n <= 1'b0;
      spi_sck  <= 1'b0;
      spi_si   <= v[i];
      repeat (4) @(posedge clk_sys);
      spi_sck  <= 1'b1;
    end
    repeat (4) @(posedge clk_sys);
    spi_sck  <= 1'b0;
    repeat (4) @(posedge clk_sys);
    spi_cs_n <= 1'b1;
    // released line shows no stale bit
    spi_si   <= ~spi_si;
  endtask : send
endmodule : spi_host_model

/* File: tb/flash_write_protection_test.sv */
// self-checking bench for the flash write-protection block
`timescale 1ns/1ps
module flash_write_protection_test;
  import flash_guard_pkg::*;
  logic        clk_sys, resetn, psel, penable, pwrite, pready, pslverr;
  logic        spi_sck, spi_cs_n, spi_si, wp_n, prog_start, erase_start;
  logic        op_chip, sr_write_start, irq, err;
  logic [7:0]  paddr, sr_value;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] op_addr;
  int          miscompares = 0, checks = 0, cycles = 0;
  int          progs = 0, erases = 0, srws = 0, n;
  // ok, status byte, target
  logic [32:0] tab [14] = '{33'h0_01_7E0000, 33'h1_01_7D0000,
    33'h0_0E_3FF000, 33'h1_0E_400000, 33'h0_11_7FF000, 33'h1_11_7FE000,
    33'h0_14_7F8000, 33'h1_14_7F7000, 33'h0_21_7DF000, 33'h1_21_7E0000,
    33'h1_27_000000, 33'h0_20_7FF000, 33'h1_39_000000, 33'h0_39_001000};
  flash_guard flash_guard_i (.clk_sys, .resetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .spi_sck, .spi_cs_n,
    .spi_si, .wp_n, .prog_start, .erase_start, .op_chip, .op_addr,
    .sr_write_start, .sr_value, .irq);
  spi_host_model spi_host_model_i (.clk_sys, .spi_sck, .spi_cs_n, .spi_si);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    progs  += (prog_start === 1'b1);
    erases += (erase_start === 1'b1);
    srws   += (sr_write_start === 1'b1);
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      wrap_up();
    end
  end
  // ------------------------------------------------
  // access tasks
  // ------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic frame(input logic [39:0] v, input int len);
    spi_host_model_i.send(v, len);
    repeat (8) @(posedge clk_sys);
  endtask : frame
  task automatic write_enable_cmd();
    frame({32'h00000000, OP_WRITE_ENABLE}, 8);
  endtask : write_enable_cmd
  task automatic srw(input logic [7:0] s);
    frame({24'h000000, OP_STATUS_WRITE, s}, 16);
  endtask : srw
  task automatic gs(input logic [7:0] s);
    apb(1'b0, REG_GUARD_STATE, 32'h0);
    chk({24'h0, rd[7:0]}, {24'h0, s});
    chk({24'h0, sr_value}, {24'h0, s});
  endtask : gs
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up
  // ------------------------------------------------
  // sequence
  // ------------------------------------------------
  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
    wp_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    gs(8'h00);
    apb(1'b0, 8'h14, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, REG_IRQ_MASK, 32'h7);
    srw(8'h01);
    gs(8'h00);
    apb(1'b0, REG_IRQ_STATUS, 32'h0);
    chk({rd[IRQ_REFUSED], irq}, 32'h3);
    apb(1'b1, REG_IRQ_MASK, 32'h0);
    // a write lands on the access edge, irq is decoded without a register and follows on that same edge
    @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, REG_IRQ_MASK, 32'h7);
    apb(1'b1, REG_IRQ_STATUS, 32'h7);
    @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    foreach (tab[i]) begin
      apb(1'b1, REG_CONTROL, 32'h1);
      write_enable_cmd();
      srw(tab[i][31:24]);
      gs(tab[i][31:24]);
      write_enable_cmd();
      apb(1'b0, REG_GUARD_STATE, 32'h0);
      chk({31'h0, rd[GS_WEL]}, 32'h1);
      n = progs;
      frame({8'h00, OP_PAGE_PROGRAM, tab[i][23:0]}, 32);
      chk(progs - n, {31'h0, tab[i][32]});
      apb(1'b0, REG_GUARD_STATE, 32'h0);
      chk({31'h0, rd[GS_VIOLATION]}, {31'h0, ~tab[i][32]});
      apb(1'b0, REG_LAST_ADDR, 32'h0);
      if (tab[i][32]) chk(rd, {8'h00, tab[i][23:0]});
    end
    write_enable_cmd();
    frame({32'h00000000, OP_CHIP_ERASE_A}, 8);
    chk(erases, 32'h0);
    write_enable_cmd();
    srw(8'h00);
    write_enable_cmd();
    frame({32'h00000000, OP_CHIP_ERASE_B}, 8);
    chk(erases, 32'h1);
    chk({7'h0, op_chip, op_addr}, 32'h01000000);
    write_enable_cmd();
    frame({8'h00, OP_SECTOR_ERASE, 24'h123000}, 32);
    chk(erases, 32'h2);
    chk({7'h0, op_chip, op_addr}, 32'h00123000);
    apb(1'b0, REG_IRQ_STATUS, 32'h0);
    chk(rd, 32'h6);
    write_enable_cmd();
    srw(8'h40);
    gs(8'h40);
    wp_n <= 1'b0;
    write_enable_cmd();
    n = srws;
    srw(8'h41);
    gs(8'h40);
    chk(srws - n, 32'h0);
    wp_n <= 1'b1;
    frame({32'h00000000, OP_WRITE_DISABLE}, 8);
    srw(8'h41);
    gs(8'h40);
    write_enable_cmd();
    n = srws;
    srw(8'h80);
    gs(8'h80);
    chk(srws - n, 32'h1);
    write_enable_cmd();
    srw(8'h00);
    gs(8'h80);
    resetn <= 1'b0;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    gs(8'h00);
    write_enable_cmd();
    srw(8'hC0);
    write_enable_cmd();
    srw(8'h00);
    gs(8'hC0);
    wrap_up();
  end
endmodule : flash_write_protection_test
